// ===== uft_pkg.sv
package uft_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] UFT_IDX_PERIOD = 8'h0d;
  localparam logic [7:0] UFT_IDX_LEFT = 8'h0e;
  localparam logic [7:0] UFT_IDX_SEQ = 8'h0f;
  localparam logic [7:0] UFT_IDX_CTRL = 8'h10;
  localparam logic [9:0] UFT_ADDR_PERIOD = {UFT_IDX_PERIOD, 2'b00};
  localparam logic [9:0] UFT_ADDR_LEFT = {UFT_IDX_LEFT, 2'b00};
  localparam logic [9:0] UFT_ADDR_SEQ = {UFT_IDX_SEQ, 2'b00};
  localparam logic [9:0] UFT_ADDR_CTRL = {UFT_IDX_CTRL, 2'b00};

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int UFT_TOGGLE_POS = 31;
  localparam int UFT_BUDGET_LSB = 16;
  localparam int UFT_BUDGET_MSB = 30;
  localparam int UFT_PERIOD_MSB = 13;
  localparam int UFT_CTRL_RESET_POS = 0;
  localparam int UFT_CTRL_OPER_POS = 1;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [13:0] UFT_PERIOD_NOMINAL = 14'h2edf; // 11999 bit times
  localparam logic [14:0] UFT_BUDGET_RESET = 15'h0000;
  localparam logic [13:0] UFT_LEFT_RESET = 14'h0000;
  localparam logic [15:0] UFT_SEQ_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int UFT_CLK_HZ = 200_000_000;
  localparam int UFT_BIT_HZ = 12_000_000;

  // controller state as seen by the frame timer
  typedef enum logic [1:0] {
    UFT_ST_HALT = 2'b00,
    UFT_ST_ENTER = 2'b01,
    UFT_ST_RUN = 2'b11
  } uft_state_type;

endpackage

// ===== uft_bit_tick.sv
`timescale 1ns/10ps
`default_nettype none
// fractional divider: one enable per full-speed bit period
module uft_bit_tick
  import uft_pkg::*;
#(
  parameter int CLK_HZ = UFT_CLK_HZ,
  parameter int BIT_HZ = UFT_BIT_HZ
)
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // tick
  output logic tick_out
);

  logic [31:0] acc_ff;
  logic [32:0] sum;
  wire logic wrap;

  // ----------------------------------------------------------------
  // phase accumulator
  // ----------------------------------------------------------------
  assign sum = {1'b0, acc_ff} + 33'(BIT_HZ);
  assign wrap = (sum >= 33'(CLK_HZ));

  // advance phase, wrap once per bit period
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      acc_ff <= 32'h0000_0000;
      tick_out <= 1'b0;
    end
    else
    begin
      acc_ff <= wrap ? 32'(sum - 33'(CLK_HZ)) : sum[31:0];
      tick_out <= wrap;
    end
  end

endmodule
`default_nettype wire

// ===== uft_frame_timing.sv
// Implementation choice: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
//
// Contract
// (RL1) Software inverts interval toggle on every new frame period write.
// (RL2) Load packet budget field into budget counter at each frame start.
// (RL3) Software computes the packet budget value; hardware does not.
// (RL4) Frame period field is 14 bits, nominal value 11999 bit times.
// (RL5) Controller soft reset returns frame period to 11999.
// (RL6) Software saves frame period before triggering soft reset.
// (RL7) Software may restore saved frame period after reset.
// (RL8) Remaining-time register is a 14-bit down counter.
// (RL9) On countdown reaching zero copy interval toggle into countdown toggle.
// (RL10) Down counter decrements by one every bit time.
// (RL11) At zero, reload counter with frame period on next bit boundary.
// (RL12) Entering operational state reloads counter from frame period.
// (RL13) 16-bit frame sequence count increments on each counter reload.
// (RL14) Sequence count wraps from maximum to zero.
// (RL15) Sequence count increments on entering operational state.
// (RL16) Software may extend sequence count to 32 bits.
// (RL17) Software may trim frame period at each frame start.
// (RL18) Bit-time tick derived from 12 MHz enable, once per bit.
//
module uft_frame_timing
  import uft_pkg::*;
#(
  parameter int PERIOD_W = 14,
  parameter int BUDGET_W = 15,
  parameter int SEQ_W = 16
)
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // register port
  input wire logic [9:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // frame timing status
  output logic sof_out,
  output logic [BUDGET_W-1:0] budget_count_out,
  output logic operational_out
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic interval_toggle_bit_ff;
  logic [BUDGET_W-1:0] packet_budget_field_ff;
  logic [PERIOD_W-1:0] sof_period_ff;
  logic countdown_toggle_bit_ff;
  logic [PERIOD_W-1:0] bit_time_countdown_ff;
  logic [SEQ_W-1:0] sof_sequence_count_ff;
  logic [BUDGET_W-1:0] budget_ff;
  logic oper_req_ff;
  uft_state_type state_ff;
  uft_state_type nxt_state;
  logic [31:0] rdata_ff;
  logic sof_ff;
  logic bit_tick;

  // ----------------------------------------------------------------
  // bit-time enable
  // ----------------------------------------------------------------
  // one pulse per 12 MHz bit period
  uft_bit_tick u_tick (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .tick_out(bit_tick) // RL18
  );

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  wire logic hit_period = (reg_addr_in == UFT_ADDR_PERIOD);
  wire logic hit_left = (reg_addr_in == UFT_ADDR_LEFT);
  wire logic hit_seq = (reg_addr_in == UFT_ADDR_SEQ);
  wire logic hit_ctrl = (reg_addr_in == UFT_ADDR_CTRL);
  wire logic wr_period = reg_wr_in && hit_period;
  wire logic wr_left = reg_wr_in && hit_left;
  wire logic wr_ctrl = reg_wr_in && hit_ctrl;
  wire logic soft_reset = wr_ctrl && reg_wdata_in[UFT_CTRL_RESET_POS];
  wire logic oper_wr = wr_ctrl && reg_wdata_in[UFT_CTRL_OPER_POS];

  // ----------------------------------------------------------------
  // frame events
  // ----------------------------------------------------------------
  wire logic running = (state_ff == UFT_ST_RUN);
  wire logic entering = (state_ff == UFT_ST_ENTER);
  wire logic at_zero = (bit_time_countdown_ff == '0);
  wire logic reload = running && bit_tick && at_zero; // RL11
  wire logic step = running && bit_tick && !at_zero; // RL10
  wire logic frame_start = reload || entering;

  // ----------------------------------------------------------------
  // controller state machine
  // ----------------------------------------------------------------
  // halt until software sets operational, one cycle enter, then run
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      UFT_ST_HALT:
      begin
        if (oper_req_ff)
        begin
          nxt_state = UFT_ST_ENTER;
        end
      end
      UFT_ST_ENTER:
      begin
        nxt_state = UFT_ST_RUN;
      end
      UFT_ST_RUN:
      begin
        if (!oper_req_ff)
        begin
          nxt_state = UFT_ST_HALT;
        end
      end
      default:
      begin
        nxt_state = UFT_ST_HALT;
      end
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in || soft_reset)
    begin
      state_ff <= UFT_ST_HALT;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // operational request bit, cleared by soft reset
  always_ff @(posedge clk_in)
  begin
    if (rst_in || soft_reset)
    begin
      oper_req_ff <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      oper_req_ff <= oper_wr;
    end
  end

  // ----------------------------------------------------------------
  // frame period setup register
  // ----------------------------------------------------------------
  // software writes toggle, budget and period; soft reset restores period
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      interval_toggle_bit_ff <= 1'b0;
      packet_budget_field_ff <= UFT_BUDGET_RESET;
      sof_period_ff <= UFT_PERIOD_NOMINAL; // RL4
    end
    else if (soft_reset)
    begin
      sof_period_ff <= UFT_PERIOD_NOMINAL; // RL5
    end
    else if (wr_period)
    begin
      interval_toggle_bit_ff <= reg_wdata_in[UFT_TOGGLE_POS];
      packet_budget_field_ff <= reg_wdata_in[UFT_BUDGET_MSB:UFT_BUDGET_LSB];
      sof_period_ff <= reg_wdata_in[UFT_PERIOD_MSB:0]; // RL4
    end
  end

  // ----------------------------------------------------------------
  // bit-time countdown and its toggle
  // ----------------------------------------------------------------
  // decrement per bit, reload at zero or on entering operational
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      bit_time_countdown_ff <= UFT_LEFT_RESET;
    end
    else if (frame_start)
    begin
      bit_time_countdown_ff <= sof_period_ff; // RL11 RL12
    end
    else if (step)
    begin
      bit_time_countdown_ff <= bit_time_countdown_ff - 1'b1; // RL8 RL10
    end
    else if (wr_left)
    begin
      bit_time_countdown_ff <= reg_wdata_in[UFT_PERIOD_MSB:0];
    end
  end

  // toggle follows the interval toggle whenever the count reloads from zero while running
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      countdown_toggle_bit_ff <= 1'b0;
    end
    else if (reload)
    begin
      countdown_toggle_bit_ff <= interval_toggle_bit_ff; // RL9
    end
    else if (wr_left)
    begin
      countdown_toggle_bit_ff <= reg_wdata_in[UFT_TOGGLE_POS];
    end
  end

  // ----------------------------------------------------------------
  // frame sequence count and packet budget counter
  // ----------------------------------------------------------------
  // count each reload and each entry to operational, wraps naturally
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      sof_sequence_count_ff <= UFT_SEQ_RESET;
    end
    else if (frame_start)
    begin
      sof_sequence_count_ff <= sof_sequence_count_ff + 1'b1; // RL13 RL14 RL15
    end
  end

  // budget loaded each frame, spends one bit per bit time
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      budget_ff <= UFT_BUDGET_RESET;
    end
    else if (frame_start)
    begin
      budget_ff <= packet_budget_field_ff; // RL2
    end
    else if (step && budget_ff != '0)
    begin
      budget_ff <= budget_ff - 1'b1;
    end
  end

  // one-cycle frame start pulse
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      sof_ff <= 1'b0;
    end
    else
    begin
      sof_ff <= frame_start;
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  wire logic [31:0] rd_period = {interval_toggle_bit_ff, packet_budget_field_ff,
                                 2'b00, sof_period_ff};
  wire logic [31:0] rd_left = {countdown_toggle_bit_ff, 17'h0_0000, bit_time_countdown_ff};
  wire logic [31:0] rd_seq = {16'h0000, sof_sequence_count_ff};
  wire logic [31:0] rd_ctrl = {30'h0000_0000, running, 1'b0};
  wire logic [31:0] rd_sel = hit_period ? rd_period :
                             hit_left ? rd_left :
                             hit_seq ? rd_seq :
                             hit_ctrl ? rd_ctrl : 32'h0000_0000;

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      rdata_ff <= 32'h0000_0000;
    end
    else if (reg_rd_in)
    begin
      rdata_ff <= rd_sel;
    end
    else
    begin
      rdata_ff <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // all straight from registers or the state decode
  assign reg_rdata_out = rdata_ff;
  assign sof_out = sof_ff;
  assign budget_count_out = budget_ff;
  assign operational_out = running;

endmodule
`default_nettype wire

// ===== uft_frame_timing_sva.sv
`timescale 1ns/10ps
`default_nettype none
module uft_frame_timing_sva
  import uft_pkg::*;
#(
  parameter int BUDGET_W = 15
)
(
  // clock, reset and register port
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [9:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  // frame status
  input wire logic sof_out,
  input wire logic [BUDGET_W-1:0] budget_count_out,
  input wire logic operational_out
);
  logic [BUDGET_W-1:0] budget_field_ff;
  wire logic wr_ctrl = reg_wr_in && reg_addr_in == UFT_ADDR_CTRL;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // shadow of the budget field last written
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      budget_field_ff <= '0;
    else if (reg_wr_in && reg_addr_in == UFT_ADDR_PERIOD)
      budget_field_ff <= reg_wdata_in[UFT_BUDGET_LSB +: BUDGET_W];
  end
  // request sequences
  sequence s_enter; wr_ctrl && reg_wdata_in[1:0] == 2'h2 && !operational_out; endsequence
  sequence s_soft_reset; wr_ctrl && reg_wdata_in[UFT_CTRL_RESET_POS]; endsequence
  sequence s_read(logic [9:0] a); reg_rd_in && reg_addr_in == a; endsequence
  // frame start and run state
  property p_sof_pulse; sof_out |=> !sof_out [*8]; endproperty
  a_sof_pulse: assert property (p_sof_pulse) else $error("frame start too long");
  property p_entry; s_enter |-> ##[1:4] (operational_out && sof_out); endproperty
  a_entry: assert property (p_entry) else $error("no frame start on entry");
  property p_halt_quiet; !operational_out [*2] |-> !sof_out; endproperty
  a_halt_quiet: assert property (p_halt_quiet) else $error("frame start in halt");
  // the counter takes the field as it stood before the load edge
  property p_budget_load; sof_out |-> budget_count_out == $past(budget_field_ff); endproperty
  a_budget_load: assert property (p_budget_load) else $error("budget not loaded");
  // soft reset and register reads
  property p_soft_reset; s_soft_reset |-> ##[1:2] !operational_out; endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("still running");
  property p_nominal; s_soft_reset ##1 !reg_wr_in ##1 s_read(UFT_ADDR_PERIOD)
    |=> reg_rdata_out[13:0] == UFT_PERIOD_NOMINAL; endproperty
  a_nominal: assert property (p_nominal) else $error("period not nominal");
  property p_left_read; s_read(UFT_ADDR_LEFT) |=> reg_rdata_out[30:14] == '0; endproperty
  a_left_read: assert property (p_left_read) else $error("count wider than 14 bits");
  property p_seq_read; s_read(UFT_ADDR_SEQ) |=> reg_rdata_out[31:16] == '0; endproperty
  a_seq_read: assert property (p_seq_read) else $error("sequence wider than 16 bits");
endmodule
bind uft_frame_timing uft_frame_timing_sva #(.BUDGET_W(BUDGET_W)) u_sva (
  .clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .sof_out(sof_out), .budget_count_out(budget_count_out), .operational_out(operational_out));
`default_nettype wire

// ===== uft_frame_timing_bench.sv
`timescale 1ns/10ps
`default_nettype none
module uft_frame_timing_bench
  import uft_pkg::*;
;
  typedef struct {logic [9:0] addr; logic [31:0] exp;} uft_row_type;
  logic clk_in, rst_in, reg_wr_in, reg_rd_in, sof_out, operational_out;
  logic [9:0] reg_addr_in;
  logic [31:0] reg_wdata_in, reg_rdata_out, rd_val;
  logic [14:0] budget_count_out;
  int n_mismatch = 0;
  int n_checks = 0;
  int gap;
  // reset values, control and an unmapped address
  uft_row_type rows [5] = '{'{UFT_ADDR_PERIOD, 32'h0000_2edf}, '{UFT_ADDR_LEFT, 32'h0},
    '{UFT_ADDR_SEQ, 32'h0}, '{UFT_ADDR_CTRL, 32'h0}, '{10'h100, 32'h0}};
  uft_frame_timing uut (.clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .sof_out(sof_out), .budget_count_out(budget_count_out),
    .operational_out(operational_out));
  // 200 MHz clock
  initial
  begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one-cycle register write and read
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1 rd_val = reg_rdata_out;
  endtask
  // bounded wait for a frame start, gap counts cycles
  task automatic wait_sof();
    gap = 0;
    do
    begin
      @(negedge clk_in);
      gap++;
    end
    while (sof_out !== 1'b1 && gap < 400);
    if (gap >= 400)
    begin
      n_mismatch++;
      print_verdict();
    end
  endtask
  initial
  begin
    rst_in = 1'b1;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    reg_addr_in = 10'h000;
    reg_wdata_in = 32'h0;
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      rd(rows[i].addr);
      chk(rd_val, rows[i].exp);
    end
    // read-only count, then a short frame with toggle set
    wr(UFT_ADDR_SEQ, 32'h0000_ffff);
    rd(UFT_ADDR_SEQ);
    chk(rd_val, 32'h0);
    wr(UFT_ADDR_PERIOD, 32'h8123_0005);
    rd(UFT_ADDR_PERIOD);
    chk(rd_val, 32'h8123_0005);
    wr(UFT_ADDR_CTRL, 32'h0000_0002);
    wait_sof();
    chk(32'(budget_count_out), 32'h0000_0123);
    chk(32'(operational_out), 32'h0000_0001);
    rd(UFT_ADDR_SEQ);
    chk(rd_val, 32'h0000_0001);
    wait_sof();
    wait_sof();
    chk(32'(gap >= 96 && gap <= 102), 32'h1);
    rd(UFT_ADDR_LEFT);
    chk({rd_val[31], 31'(rd_val[13:0] <= 14'h0005)}, 32'h8000_0001);
    rd(UFT_ADDR_SEQ);
    chk(rd_val, 32'h0000_0003);
    // toggle cleared with the next period write, just after a frame start
    wr(UFT_ADDR_PERIOD, 32'h0123_0005);
    wait_sof();
    rd(UFT_ADDR_LEFT);
    chk(32'(rd_val[31]), 32'h0);
    // save the period, soft reset, then restore and re-enter
    rd(UFT_ADDR_PERIOD);
    chk(rd_val, 32'h0123_0005);
    wr(UFT_ADDR_CTRL, 32'h0000_0001);
    rd(UFT_ADDR_PERIOD);
    chk(rd_val, 32'h0123_2edf);
    chk(32'(operational_out), 32'h0000_0000);
    wr(UFT_ADDR_PERIOD, 32'h0123_0005);
    wr(UFT_ADDR_CTRL, 32'h0000_0002);
    wait_sof();
    rd(UFT_ADDR_SEQ);
    chk(rd_val, 32'h0000_0005);
    // second reset in mid-run
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(UFT_ADDR_SEQ);
    chk(rd_val, 32'h0);
    chk(32'(operational_out), 32'h0000_0000);
    print_verdict();
  end
endmodule
`default_nettype wire
